/* verilog/incr_exec_pkg.sv */
// Operation
// - Byte operand gains one, 0xFF wraps to 0x00, status flags never touched
// - Register form 00001rrr and indirect form 0000011i, one byte each
// - Opcode 0x05 increments the direct address given by byte two, one cycle
// - Port target reads the output latch, not pins, and writes back the latch
// - Data pointer increments by one modulo 2^16, the only 16-bit increment
// - Low pointer byte rolling 0xFF to 0x00 carries into high byte, no flags
`default_nettype none
package incr_exec_pkg;

  // ==========================================================================
  // Opcodes and fields
  localparam logic [7:0] OP_INC_ACC       = 8'h04;
  localparam logic [7:0] OP_INC_DIRECT    = 8'h05;
  localparam logic [7:0] OP_INC_DATA_POINTER      = 8'hA3;
  localparam logic [4:0] OP_REG_PREFIX    = 5'h01;
  localparam logic [6:0] OP_IND_PREFIX    = 7'h03;
  localparam logic [7:0] BYTE_ONE         = 8'h01;
  localparam logic [15:0] WORD_ONE        = 16'h0001;
  localparam logic [7:0] BYTE_ALL_ONES    = 8'hFF;

  // Port latches sit at 0x80, 0x90, 0xA0 and 0xB0
  localparam logic [7:0] PORT_ADDR_MASK   = 8'hCF;
  localparam logic [7:0] PORT_ADDR_MATCH  = 8'h80;

  // Machine cycles per instruction
  localparam int MC_SHORT = 1;
  localparam int MC_DATA_POINTER  = 2;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SPACE_ACC,
    SPACE_REG,
    SPACE_DIRECT,
    SPACE_IRAM,
    SPACE_LATCH
  } space_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    space_t     space;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_req_t;

endpackage
`default_nettype wire

/* verilog/increment_instruction_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module increment_instruction_exec #(
  parameter int CLKS_PER_MC = 4
) (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic                    clkEn,
  input  wire logic                    start,
  input  wire logic [7:0]              opcode,
  input  wire logic [7:0]              operandByte,
  input  wire logic [7:0]              rdData,
  input  wire logic                    pointerLoad,
  input  wire logic [15:0]             pointerLoadValue,
  output var  incr_exec_pkg::mem_req_t memReq,
  output logic                         busy,
  output logic                         done,
  output logic                         unsupported,
  output logic [15:0]                  dataPointer
);

  // ==========================================================================
  // Decode
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH_PTR,
    ST_READ,
    ST_HOLD
  } state_t;

  localparam logic [7:0] TARGET_SHORT = 8'(incr_exec_pkg::MC_SHORT * CLKS_PER_MC - 1);
  localparam logic [7:0] TARGET_DATA_POINTER  = 8'(incr_exec_pkg::MC_DATA_POINTER * CLKS_PER_MC - 1);

  state_t                  state_q;
  logic [7:0]              cyc_q;
  logic [7:0]              target_q;
  incr_exec_pkg::mem_req_t memReq_q;
  logic                    busy_q;
  logic                    done_q;
  logic                    unsupported_q;
  logic [15:0]             dataPointer_q;

  logic isAcc;
  logic isReg;
  logic isInd;
  logic isDir;
  logic isDptr;
  logic accept;
  logic dirIsPort;

  always_comb
  begin
    isAcc     = (opcode == incr_exec_pkg::OP_INC_ACC);
    isReg     = (opcode[7:3] == incr_exec_pkg::OP_REG_PREFIX);
    isInd     = (opcode[7:1] == incr_exec_pkg::OP_IND_PREFIX);
    isDir     = (opcode == incr_exec_pkg::OP_INC_DIRECT);
    isDptr    = (opcode == incr_exec_pkg::OP_INC_DATA_POINTER);
    accept    = clkEn && start && (state_q == ST_IDLE);
    dirIsPort = ((operandByte & incr_exec_pkg::PORT_ADDR_MASK)
                 == incr_exec_pkg::PORT_ADDR_MATCH);
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      // Kept as its own flop so the port is not a decode of the state
      busy_q <= (state_q == ST_IDLE) ? (accept && (isAcc || isReg || isInd || isDir || isDptr))
                                     : !((state_q == ST_HOLD) && (cyc_q == target_q));
      case (state_q)
        ST_IDLE:
        begin
          if (accept && (isAcc || isReg || isDir))
            state_q <= ST_READ;
          else if (accept && isInd)
            state_q <= ST_FETCH_PTR;
          else if (accept && isDptr)
            state_q <= ST_HOLD;
        end
        ST_FETCH_PTR: state_q <= ST_READ;
        ST_READ:      state_q <= ST_HOLD;
        ST_HOLD:
        begin
          if (cyc_q == target_q)
            state_q <= ST_IDLE;
        end
        default:      state_q <= ST_IDLE;
      endcase
    end
  end

  // Whole instruction length is fixed by the machine-cycle count, not by
  // how fast the operand traffic finished
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cyc_q    <= 8'h00;
      target_q <= 8'h00;
    end
    else if (clkEn)
    begin
      if (accept)
      begin
        cyc_q    <= 8'h00;
        target_q <= isDptr ? TARGET_DATA_POINTER : TARGET_SHORT;
      end
      else if (state_q != ST_IDLE)
        cyc_q <= cyc_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_q        <= 1'b0;
      unsupported_q <= 1'b0;
    end
    else if (clkEn)
    begin
      done_q        <= (state_q == ST_HOLD) && (cyc_q == target_q);
      unsupported_q <= accept && !(isAcc || isReg || isInd || isDir || isDptr);
    end
  end

  // ==========================================================================
  // Operand traffic: read, then write back the value plus one.
  // No flag space exists on this port, so the status word is never written.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memReq_q <= '0;
    end
    else if (clkEn)
    begin
      memReq_q.rd <= 1'b0;
      memReq_q.wr <= 1'b0;
      if (accept && isAcc)
      begin
        memReq_q.rd    <= 1'b1;
        memReq_q.space <= incr_exec_pkg::SPACE_ACC;
        memReq_q.addr  <= 8'h00;
      end
      else if (accept && isReg)
      begin
        memReq_q.rd    <= 1'b1;
        memReq_q.space <= incr_exec_pkg::SPACE_REG;
        memReq_q.addr  <= {5'h00, opcode[2:0]};
      end
      else if (accept && isInd)
      begin
        memReq_q.rd    <= 1'b1;
        memReq_q.space <= incr_exec_pkg::SPACE_REG;
        memReq_q.addr  <= {7'h00, opcode[0]};
      end
      else if (accept && isDir)
      begin
        memReq_q.rd    <= 1'b1;
        memReq_q.space <= dirIsPort ? incr_exec_pkg::SPACE_LATCH
                                    : incr_exec_pkg::SPACE_DIRECT;
        memReq_q.addr  <= operandByte;
      end
      else if (state_q == ST_FETCH_PTR)
      begin
        memReq_q.rd    <= 1'b1;
        memReq_q.space <= incr_exec_pkg::SPACE_IRAM;
        memReq_q.addr  <= rdData;
      end
      else if (state_q == ST_READ)
      begin
        // Same space and address as the read, so a port goes back to its latch
        memReq_q.wr   <= 1'b1;
        memReq_q.data <= rdData + incr_exec_pkg::BYTE_ONE;
      end
    end
  end

  // ==========================================================================
  // Data pointer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataPointer_q <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (accept && isDptr)
        dataPointer_q <= dataPointer_q + incr_exec_pkg::WORD_ONE;
      else if (pointerLoad)
        dataPointer_q <= pointerLoadValue;
    end
  end

  assign memReq      = memReq_q;
  assign busy        = busy_q;
  assign done        = done_q;
  assign unsupported = unsupported_q;
  assign dataPointer = dataPointer_q;

  // ==========================================================================
  // Checks
  logic [7:0] elapsed_q;
  logic [7:0] expect_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      elapsed_q <= 8'h00;
      expect_q  <= 8'h00;
    end
    else if (clkEn)
    begin
      if (accept)
      begin
        elapsed_q <= 8'h00;
        expect_q  <= (opcode == incr_exec_pkg::OP_INC_DATA_POINTER) ? 8'(2 * CLKS_PER_MC)
                                                            : 8'(CLKS_PER_MC);
      end
      else if (state_q != ST_IDLE)
        elapsed_q <= elapsed_q + 8'h01;
    end
  end

  property p_inc_wrap;
    @(posedge sys_clk) disable iff (!arst_n)
    (clkEn && state_q == ST_READ) |=> memReq.wr && memReq.data == 8'($past(rdData) + 8'h01);
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("write value is not read value plus one");

  property p_reg_form;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode[7:3] == 5'h01) |=> memReq.rd && memReq.space == incr_exec_pkg::SPACE_REG
      && memReq.addr == {5'h00, $past(opcode[2:0])};
  endproperty
  a_reg_form: assert property (p_reg_form) else $error("register form read wrong register");

  property p_ind_form;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode[7:1] == 7'h03) ##1 clkEn |=> memReq.rd
      && memReq.space == incr_exec_pkg::SPACE_IRAM && memReq.addr == $past(rdData);
  endproperty
  a_ind_form: assert property (p_ind_form) else $error("indirect read not at pointer value");

  property p_direct;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode == 8'h05 && operandByte[3:0] != 4'h0) |=> memReq.rd
      && memReq.space == incr_exec_pkg::SPACE_DIRECT && memReq.addr == $past(operandByte);
  endproperty
  a_direct: assert property (p_direct) else $error("direct form read wrong address");

  property p_port_latch;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode == 8'h05 && operandByte[7:6] == 2'h2 && operandByte[3:0] == 4'h0)
      ##1 clkEn ##1 clkEn |-> memReq.wr && memReq.space == incr_exec_pkg::SPACE_LATCH;
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port write-back not to latch");

  property p_data_pointer_inc;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode == 8'hA3) |=> dataPointer == 16'($past(dataPointer) + 16'h0001);
  endproperty
  a_data_pointer_inc: assert property (p_data_pointer_inc) else $error("pointer did not advance by one");

  property p_data_pointer_carry;
    @(posedge sys_clk) disable iff (!arst_n)
    (accept && opcode == 8'hA3 && dataPointer[7:0] == 8'hFF) |=> dataPointer[7:0] == 8'h00
      && dataPointer[15:8] == 8'($past(dataPointer[15:8]) + 8'h01);
  endproperty
  a_data_pointer_carry: assert property (p_data_pointer_carry) else $error("low byte rollover lost carry");

  property p_mc_length;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(done) |-> elapsed_q == expect_q;
  endproperty
  a_mc_length: assert property (p_mc_length) else $error("instruction length wrong");

  c_acc:  cover property (@(posedge sys_clk) disable iff (!arst_n) accept && opcode == 8'h04);
  c_ind:  cover property (@(posedge sys_clk) disable iff (!arst_n) accept && opcode == 8'h07);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!arst_n)
                          memReq.wr && memReq.data == 8'h00);
  c_dpc:  cover property (@(posedge sys_clk) disable iff (!arst_n)
                          accept && opcode == 8'hA3 && dataPointer[7:0] == 8'hFF);

endmodule
`default_nettype wire

/* test/increment_instruction_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module increment_instruction_exec_tb;
  // ==========================================================================
  // Signals
  localparam int CPM = 4;
  typedef struct packed {
    logic        dn;
    logic        un;
    logic [15:0] ptr;
    logic [31:0] at;
  } note_t;
  logic                    sys_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    clkEn = 1'b1;
  logic                    start = 1'b0;
  logic [7:0]              opcode = 8'h00;
  logic [7:0]              operandByte = 8'h00;
  logic [7:0]              rdData;
  logic                    pointerLoad = 1'b0;
  logic [15:0]             pointerLoadValue = 16'h0000;
  incr_exec_pkg::mem_req_t memReq;
  logic                    busy;
  logic                    done;
  logic                    unsupported;
  logic [15:0]             dataPointer;
  logic [7:0]              mem [0:4][0:255];
  logic [31:0]             cyc = 32'h0000_0000;
  logic [15:0]             ptr = 16'h0000;
  note_t                   nExp;
  int                      errors = 0;
  int                      comparisons = 0;
  incr_exec_pkg::mem_req_t wrQ[$];
  note_t                   endQ[$];

  always #12.5 sys_clk = ~sys_clk;
  // Unread cycles see a moving pattern so a stale read cannot pass
  assign rdData = memReq.rd ? mem[memReq.space][memReq.addr] : cyc[7:0];

  increment_instruction_exec #(.CLKS_PER_MC(CPM)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .start(start),
    .opcode(opcode), .operandByte(operandByte), .rdData(rdData),
    .pointerLoad(pointerLoad), .pointerLoadValue(pointerLoadValue),
    .memReq(memReq), .busy(busy), .done(done), .unsupported(unsupported),
    .dataPointer(dataPointer));

  // ==========================================================================
  // Checking
  task automatic check(input string name, input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 32'h0000_0001;
    if (cyc == 32'h0000_1770)
    begin
      errors++;
      stop_test();
    end
  end

  // Core side: writes land in the memory image, results pop the oldest note
  always @(posedge sys_clk)
  begin
    if (arst_n && memReq.wr === 1'b1)
    begin
      mem[memReq.space][memReq.addr] <= memReq.data;
      check("wrPending", wrQ.size() > 0, 1);
      if (wrQ.size() > 0)
        check("memReq", memReq, wrQ.pop_front());
    end
    if (arst_n && (done === 1'b1 || unsupported === 1'b1))
    begin
      check("notePending", endQ.size() > 0, 1);
      nExp = '0;
      if (endQ.size() > 0)
        nExp = endQ.pop_front();
      check("done", done, nExp.dn);
      check("unsupported", unsupported, nExp.un);
      check("dataPointer", dataPointer, nExp.ptr);
      check("doneCycle", cyc, nExp.at);
    end
  end

  // ==========================================================================
  // Driving
  function automatic logic is_port(input logic [7:0] a);
    return a == 8'h80 || a == 8'h90 || a == 8'hA0 || a == 8'hB0;
  endfunction

  task automatic run(input logic [7:0] op, input logic [7:0] arg);
    incr_exec_pkg::mem_req_t w;
    note_t                   n;
    logic                    fam;
    int                      k;
    fam = op inside {8'h04, 8'h05, 8'h06, 8'h07, 8'hA3} || op[7:3] == 5'h01;
    w = '0;
    w.wr = 1'b1;
    w.space = op == 8'h04 ? incr_exec_pkg::SPACE_ACC
            : op[7:3] == 5'h01 ? incr_exec_pkg::SPACE_REG
            : op != 8'h05 ? incr_exec_pkg::SPACE_IRAM
            : is_port(arg) ? incr_exec_pkg::SPACE_LATCH : incr_exec_pkg::SPACE_DIRECT;
    w.addr = op[7:3] == 5'h01 ? {5'h00, op[2:0]} : op == 8'h05 ? arg
           : op[7:1] == 7'h03 ? mem[incr_exec_pkg::SPACE_REG][{7'h00, op[0]}] : 8'h00;
    w.data = mem[w.space][w.addr] + 8'h01;
    n.dn = fam;
    n.un = ~fam;
    n.ptr = (op == 8'hA3) ? ptr + 16'h0001 : ptr;
    n.at = cyc + 32'((op == 8'hA3) ? 2 * CPM : fam ? CPM : 0) + 32'h0000_0001;
    ptr = n.ptr;
    if (fam && op != 8'hA3)
      wrQ.push_back(w);
    endQ.push_back(n);
    start = 1'b1;
    opcode = op;
    operandByte = arg;
    // A load in the same edge as the increment must lose
    pointerLoad = (op == 8'hA3);
    pointerLoadValue = 16'($urandom());
    @(negedge sys_clk);
    check("busy", busy, fam);
    pointerLoad = 1'b0;
    start = fam;
    // Requests while busy are junk and must be refused
    for (k = 0; k < 20 && fam && done !== 1'b1; k++)
    begin
      opcode = 8'($urandom());
      operandByte = 8'($urandom());
      @(negedge sys_clk);
    end
    if (!fam)
      @(negedge sys_clk);
  endtask

  task automatic load(input logic [15:0] v);
    start = 1'b0;
    pointerLoad = 1'b1;
    pointerLoadValue = v;
    ptr = v;
    @(negedge sys_clk);
    pointerLoad = 1'b0;
    @(negedge sys_clk);
    check("loaded", dataPointer, ptr);
  endtask

  // With the enable low a pending start and load must both be ignored
  task automatic freeze();
    clkEn = 1'b0;
    start = 1'b1;
    opcode = incr_exec_pkg::OP_INC_DATA_POINTER;
    pointerLoad = 1'b1;
    pointerLoadValue = ~ptr;
    repeat (2) @(negedge sys_clk);
    check("frozenPtr", dataPointer, ptr);
    check("frozenBusy", busy, 0);
    clkEn = 1'b1;
    start = 1'b0;
    pointerLoad = 1'b0;
    @(negedge sys_clk);
  endtask

  initial
  begin
    int i;
    void'($urandom(56));
    for (i = 0; i < 5 * 256; i++)
      mem[i / 256][i % 256] = 8'($urandom());
    mem[incr_exec_pkg::SPACE_REG][0] = 8'h7E;
    mem[incr_exec_pkg::SPACE_IRAM][8'h7E] = 8'hFF;
    mem[incr_exec_pkg::SPACE_IRAM][8'h7F] = 8'h40;
    mem[incr_exec_pkg::SPACE_ACC][0] = 8'hFF;
    mem[incr_exec_pkg::SPACE_DIRECT][8'h30] = 8'hFF;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    check("resetState", {memReq, busy, done, unsupported, dataPointer}, 0);
    run(8'h04, 8'h00);
    run(8'h06, 8'h00);
    run(8'h08, 8'h00);
    run(8'h06, 8'h00);
    run(8'h05, 8'h30);
    for (i = 0; i < 8; i++)
      run({5'h01, 3'(i)}, 8'($urandom()));
    run(8'h07, 8'h00);
    for (i = 8; i < 12; i++)
      run(8'h05, {4'(i), 4'h0});
    for (i = 0; i < 6; i++)
      run(8'h05, 8'($urandom()));
    load(16'h12FE);
    freeze();
    repeat (3) run(8'hA3, 8'h00);
    load(16'hFFFF);
    run(8'hA3, 8'h00);
    run(8'h00, 8'h00);
    run(8'hA4, 8'h00);
    for (i = 0; i < 6; i++)
      run(8'($urandom()), 8'($urandom()));
    start = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("pending", wrQ.size() + endQ.size(), 0);
    stop_test();
  end
endmodule
`default_nettype wire
